// *** bench/cvt_crt_model.sv ***
// crt side model: drives horizontal sync and character clock pins
`timescale 1ns/1ps
`default_nettype none
module cvt_crt_model (
  // clock
  input wire logic clk_in,
  // pins toward the block
  output logic hsync_pin_out,
  output logic char_clk_pin_out
);
  initial begin
    hsync_pin_out = 1'b0;
    char_clk_pin_out = 1'b0;
  end

  // one sync pulse, wide enough for the pin filter
  task automatic line_pulse();
    @(negedge clk_in) hsync_pin_out = 1'b1;
    repeat (6) @(negedge clk_in);
    hsync_pin_out = 1'b0;
    repeat (8) @(negedge clk_in);
  endtask : line_pulse

  // char clock runs only while asked, else stands low
  task automatic char_ticks(input int n);
    repeat (n) begin
      @(negedge clk_in) char_clk_pin_out = 1'b1;
      repeat (6) @(negedge clk_in);
      char_clk_pin_out = 1'b0;
      repeat (5) @(negedge clk_in);
    end
    repeat (8) @(negedge clk_in);
  endtask : char_ticks
endmodule : cvt_crt_model
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the crtc vertical timing block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import cvt_pkg::*;
;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  cvt_io_req_t io_req = '0;
  logic [7:0] rdata;
  logic [LINE_W-1:0] vtotal = 10'h009;
  logic [ADDR_W-1:0] sstart = 16'h1234;
  logic [4:0] rscan = 5'h00;
  logic hs_pin;
  logic cc_pin;
  cvt_timing_t tim;
  logic [ADDR_W-1:0] maddr;
  logic [2:0] rcnt;
  logic pend;
  logic irq;
  logic [15:0] row;
  int err_total = 0;
  int n_tests = 0;

  always #10 clk_in = ~clk_in;

  cvt_vertical_timing cvt_vertical_timing_inst (
    .clk_in(clk_in), .rstn_in(rstn_in), .io_req_in(io_req),
    .io_rdata_out(rdata), .vertical_total_in(vtotal),
    .screen_start_in(sstart), .row_scan_in(rscan),
    .hsync_pin_in(hs_pin), .char_clk_pin_in(cc_pin),
    .timing_out(tim), .mem_addr_out(maddr), .refresh_count_out(rcnt),
    .vertical_irq_pending_out(pend), .irq_out(irq)
  );

  cvt_crt_model cvt_crt_model_inst (
    .clk_in(clk_in), .hsync_pin_out(hs_pin), .char_clk_pin_out(cc_pin)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic sel, input logic [7:0] d);
    @(negedge clk_in) io_req = '{sel_data: sel, wr: 1'b1, wdata: d};
    @(negedge clk_in) io_req.wr = 1'b0;
  endtask : wr

  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    wr(1'b0, idx);
    wr(1'b1, d);
  endtask : wreg

  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    wr(1'b0, idx);
    repeat (3) @(negedge clk_in);
    chk(16'(rdata), 16'(exp), "register read");
  endtask : rchk

  task automatic pulse();
    cvt_crt_model_inst.line_pulse();
  endtask : pulse

  task automatic done(input string name);
    $display("test %s ended, mismatches %0d", name, err_total);
  endtask : done

  task automatic t_reset();
    chk(16'(rcnt), 16'h0003, "refresh count");
    chk(16'(irq), 16'h0000, "irq after reset");
    rchk(IDX_VSYNC_END, VSE_RESET);
    done("reset");
  endtask : t_reset

  task automatic t_regs();
    wreg(IDX_CURSOR_HIGH, 8'ha5);
    wreg(IDX_CURSOR_LOW, 8'h5a);
    rchk(IDX_CURSOR_HIGH, 8'ha5);
    rchk(IDX_CURSOR_LOW, 8'h5a);
    rchk(8'h20, 8'h00);
    done("registers");
  endtask : t_regs

  task automatic t_protect();
    wreg(IDX_VSYNC_END, 8'h90);
    wreg(IDX_OVERFLOW, 8'hff);
    rchk(IDX_OVERFLOW, 8'h10);
    wreg(IDX_VSYNC_END, 8'h55);
    repeat (2) @(negedge clk_in);
    chk(16'(rcnt), 16'h0005, "refresh five");
    wreg(IDX_VSYNC_END, 8'h15);
    repeat (2) @(negedge clk_in);
    chk(16'(rcnt), 16'h0003, "refresh three");
    done("protect");
  endtask : t_protect

  task automatic t_disabled();
    wreg(IDX_VSYNC_START, 8'h03);
    wreg(IDX_VDISP_END, 8'h02);
    wreg(IDX_VBLANK_START, 8'h06);
    wreg(IDX_VBLANK_END, 8'h08);
    wreg(IDX_PITCH, 8'h10);
    repeat (4) pulse();
    chk(16'(tim), 16'h0000, "timing while disabled");
    done("disabled");
  endtask : t_disabled

  task automatic t_frame();
    int l;
    wreg(IDX_MODE, 8'hc3);
    for (int k = 1; k <= 13; k++) begin
      pulse();
      l = k % 10;
      chk(16'(tim.vsync), 16'(l == 3 || l == 4), "vsync");
      chk(16'(tim.vblank), 16'(l == 6 || l == 7), "vblank");
      if (k >= 2) begin
        chk(16'(tim.display_active), 16'(l < 2), "display");
      end
      if (k == 3) begin
        chk(16'({pend, irq}), 16'h0003, "irq raised");
        wreg(IDX_VSYNC_END, 8'h05);
        repeat (2) @(negedge clk_in);
        chk(16'({pend, irq}), 16'h0000, "irq cleared");
      end
      if (k == 4) begin
        wreg(IDX_VSYNC_END, 8'h35);
      end
    end
    chk(16'({pend, irq}), 16'h0000, "irq disabled");
    done("frame");
  endtask : t_frame

  task automatic t_addr();
    repeat (7) pulse();
    row = sstart;
    chk(maddr, row, "line zero start");
    pulse();
    row = row + 16'h0020;
    chk(maddr, row, "byte mode row");
    wreg(IDX_MODE, 8'h83);
    pulse();
    row = row + 16'h0040;
    chk(maddr, {row[15:14], row[12:0], row[13]}, "word wrap14");
    wreg(IDX_MODE, 8'ha3);
    pulse();
    row = row + 16'h0040;
    chk(maddr, {row[14:0], row[15]}, "word wrap16");
    wreg(IDX_UNDERLINE, 8'h60);
    wreg(IDX_MODE, 8'hc3);
    pulse();
    row = row + 16'h0020;
    chk(maddr, {row[15:14], row[11:0], row[13:12]}, "dword");
    wreg(IDX_UNDERLINE, 8'h00);
    pulse();
    row = row + 16'h0020;
    cvt_crt_model_inst.char_ticks(4);
    chk(maddr, row + 16'h0004, "char count");
    wreg(IDX_MODE, 8'hcb);
    pulse();
    row = row + 16'h0020;
    cvt_crt_model_inst.char_ticks(4);
    chk(maddr, row + 16'h0002, "count by two");
    rscan = 5'h01;
    wreg(IDX_MODE, 8'hc2);
    pulse();
    row = row + 16'h0020;
    chk(maddr, row | 16'h4000, "row scan swap");
    done("address");
  endtask : t_addr

  task automatic t_misc();
    wreg(IDX_MODE, 8'hc7);
    repeat (4) pulse();
    row = row + 16'h0040;
    chk(maddr, row, "every second sync");
    wreg(IDX_CURSOR_HIGH, row[15:8]);
    wreg(IDX_CURSOR_LOW, row[7:0]);
    repeat (2) @(negedge clk_in);
    chk(16'(tim.cursor_hit), 16'h0001, "cursor hit");
    cvt_crt_model_inst.char_ticks(1);
    chk(16'(tim.cursor_hit), 16'h0000, "cursor moved off");
    wreg(IDX_UNDERLINE, 8'h01);
    repeat (2) @(negedge clk_in);
    chk(16'(tim.underline), 16'h0001, "underline line");
    rscan = 5'h02;
    repeat (2) @(negedge clk_in);
    chk(16'(tim.underline), 16'h0000, "underline off");
    done("misc");
  endtask : t_misc

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    repeat (10) @(negedge clk_in);
    rstn_in = 1'b1;
    t_reset();
    t_regs();
    t_protect();
    t_disabled();
    t_frame();
    t_addr();
    t_misc();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire

// *** hdl/cvt_pin_sync.sv ***
// three-flop pin synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
`default_nettype none
module cvt_pin_sync (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // pin and filtered result
  input wire logic pin_in,
  output logic level_out,
  output logic rise_out
);
  logic s1_q, s2_q, s3_q, level_q, rise_q;
  logic level_d, rise_d;

  always_comb begin
    level_d = level_q;
    if (s2_q == s3_q) begin
      level_d = s3_q;
    end
    rise_d = level_d & ~level_q;
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
      rise_q <= rise_d;
    end
  end

  assign level_out = level_q;
  assign rise_out = rise_q;
endmodule : cvt_pin_sync
`default_nettype wire

// *** hdl/cvt_pkg.sv ***
// constants, types and field layout for the crtc vertical timing block
// Summary of operation
// - sixteen-bit cursor address in high/low registers
// - vertical sync starts at sync start line
// - write protect blocks indexes 0-7 except bit4
// - refresh cycles per line: five or three
// - disable bit keeps interrupt output inactive
// - writing zero to clear bit clears pending
// - sync ends when low four line bits match
// - active display ends at display end line
// - row start adds offset each new line
// - offset shifted one or two by mode bit
// - doubleword mode rotates address counter left two
// - count-by-four divides address clock by four
// - underline drawn on matching cell scanline
// - vertical blank starts at blank start line
// - vertical blank ends on blank end match
// - timing enable bit stops or runs timing
// - byte mode unrotated, word mode rotate one
// - address wrap picks sixteen or fourteen bits
// - count-by-two halves address counter clock
// - multiply bit advances lines every second sync
// - sync start compare is ten bits wide
// - row scan bits replace counter bit fourteen
package cvt_pkg;
  localparam logic [7:0] IDX_OVERFLOW = 8'h07;
  localparam logic [7:0] IDX_CURSOR_HIGH = 8'h0E;
  localparam logic [7:0] IDX_CURSOR_LOW = 8'h0F;
  localparam logic [7:0] IDX_VSYNC_START = 8'h10;
  localparam logic [7:0] IDX_VSYNC_END = 8'h11;
  localparam logic [7:0] IDX_VDISP_END = 8'h12;
  localparam logic [7:0] IDX_PITCH = 8'h13;
  localparam logic [7:0] IDX_UNDERLINE = 8'h14;
  localparam logic [7:0] IDX_VBLANK_START = 8'h15;
  localparam logic [7:0] IDX_VBLANK_END = 8'h16;
  localparam logic [7:0] IDX_MODE = 8'h17;
  localparam logic [7:0] IDX_EXT_DISPLAY = 8'h1B;
  localparam logic [7:0] IDX_PROTECT_LAST = 8'h07;
  // vsync end register fields
  localparam int VSE_PROTECT = 7;
  localparam int VSE_REFRESH = 6;
  localparam int VSE_IRQ_DIS = 5;
  localparam int VSE_IRQ_CLR = 4;
  // vertical overflow fields
  localparam int OVF_VSS9 = 7;
  localparam int OVF_VDE9 = 6;
  localparam int OVF_LC8 = 4;
  localparam int OVF_VBS8 = 3;
  localparam int OVF_VSS8 = 2;
  localparam int OVF_VDE8 = 1;
  // underline register fields
  localparam int UL_DWORD = 6;
  localparam int UL_CNT4 = 5;
  // mode control fields
  localparam int MC_TIMING_EN = 7;
  localparam int MC_BYTE_MODE = 6;
  localparam int MC_WRAP = 5;
  localparam int MC_CNT2 = 3;
  localparam int MC_MULT_V = 2;
  localparam int MC_ROWSEL1 = 1;
  localparam int MC_ROWSEL0 = 0;
  // extended display fields
  localparam int EXT_VBE_EXT = 5;
  localparam int EXT_PITCH8 = 4;
  // reset values and protected write mask
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] VSE_RESET = 8'h10;
  localparam logic [7:0] OVF_WMASK_PROT = 8'h10;
  // refresh cycle counts, line and address widths
  localparam logic [2:0] REFRESH_HI = 3'h5;
  localparam logic [2:0] REFRESH_LO = 3'h3;
  localparam int LINE_W = 10;
  localparam int ADDR_W = 16;

  typedef struct packed {
    logic sel_data;
    logic wr;
    logic [7:0] wdata;
  } cvt_io_req_t;

  typedef struct packed {
    logic vsync;
    logic vblank;
    logic display_active;
    logic underline;
    logic cursor_hit;
  } cvt_timing_t;
endpackage : cvt_pkg

// *** hdl/cvt_vertical_timing.sv ***
// crtc vertical timing, addressing modes and indexed register port
`timescale 1ns/1ps
`default_nettype none
module cvt_vertical_timing
  import cvt_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // indexed register port
  input wire cvt_io_req_t io_req_in,
  output logic [7:0] io_rdata_out,
  // link to the rest of the crtc
  input wire logic [LINE_W-1:0] vertical_total_in,
  input wire logic [ADDR_W-1:0] screen_start_in,
  input wire logic [4:0] row_scan_in,
  // pins
  input wire logic hsync_pin_in,
  input wire logic char_clk_pin_in,
  // timing outputs
  output cvt_timing_t timing_out,
  output logic [ADDR_W-1:0] mem_addr_out,
  output logic [2:0] refresh_count_out,
  output logic vertical_irq_pending_out,
  output logic irq_out
);
  // register file
  logic [7:0] index_q, index_d;
  logic [7:0] ovf_q, ovf_d, ext_q, ext_d;
  logic [7:0] curh_q, curh_d, curl_q, curl_d;
  logic [7:0] vss_q, vss_d, vse_q, vse_d, vde_q, vde_d;
  logic [7:0] pitch_q, pitch_d, ul_q, ul_d;
  logic [7:0] vbs_q, vbs_d, vbe_q, vbe_d, mode_q, mode_d;
  logic [7:0] rdata_q, rdata_d;
  logic data_wr, clr_wr;

  always_comb begin
    data_wr = io_req_in.sel_data & io_req_in.wr;
    clr_wr = data_wr & (index_q == IDX_VSYNC_END)
      & ~io_req_in.wdata[VSE_IRQ_CLR];
    index_d = index_q;
    ovf_d = ovf_q;
    ext_d = ext_q;
    curh_d = curh_q;
    curl_d = curl_q;
    vss_d = vss_q;
    vse_d = vse_q;
    vde_d = vde_q;
    pitch_d = pitch_q;
    ul_d = ul_q;
    vbs_d = vbs_q;
    vbe_d = vbe_q;
    mode_d = mode_q;
    if (io_req_in.wr && !io_req_in.sel_data) begin
      index_d = io_req_in.wdata;
    end
    if (data_wr) begin
      case (index_q)
        IDX_OVERFLOW: begin
          if (vse_q[VSE_PROTECT]) begin
            ovf_d = (ovf_q & ~OVF_WMASK_PROT)
              | (io_req_in.wdata & OVF_WMASK_PROT);
          end else begin
            ovf_d = io_req_in.wdata;
          end
        end
        IDX_CURSOR_HIGH: curh_d = io_req_in.wdata;
        IDX_CURSOR_LOW: curl_d = io_req_in.wdata;
        IDX_VSYNC_START: vss_d = io_req_in.wdata;
        IDX_VSYNC_END: vse_d = io_req_in.wdata;
        IDX_VDISP_END: vde_d = io_req_in.wdata;
        IDX_PITCH: pitch_d = io_req_in.wdata;
        IDX_UNDERLINE: ul_d = io_req_in.wdata;
        IDX_VBLANK_START: vbs_d = io_req_in.wdata;
        IDX_VBLANK_END: vbe_d = io_req_in.wdata;
        IDX_MODE: mode_d = io_req_in.wdata;
        IDX_EXT_DISPLAY: ext_d = io_req_in.wdata;
        default: ovf_d = ovf_q;
      endcase
    end
    case (index_q)
      IDX_OVERFLOW: rdata_d = ovf_q;
      IDX_CURSOR_HIGH: rdata_d = curh_q;
      IDX_CURSOR_LOW: rdata_d = curl_q;
      IDX_VSYNC_START: rdata_d = vss_q;
      IDX_VSYNC_END: rdata_d = vse_q;
      IDX_VDISP_END: rdata_d = vde_q;
      IDX_PITCH: rdata_d = pitch_q;
      IDX_UNDERLINE: rdata_d = ul_q;
      IDX_VBLANK_START: rdata_d = vbs_q;
      IDX_VBLANK_END: rdata_d = vbe_q;
      IDX_MODE: rdata_d = mode_q;
      IDX_EXT_DISPLAY: rdata_d = ext_q;
      default: rdata_d = REG_RESET;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      index_q <= REG_RESET;
      ovf_q <= REG_RESET;
      ext_q <= REG_RESET;
      curh_q <= REG_RESET;
      curl_q <= REG_RESET;
      vss_q <= REG_RESET;
      vse_q <= VSE_RESET;
      vde_q <= REG_RESET;
      pitch_q <= REG_RESET;
      ul_q <= REG_RESET;
      vbs_q <= REG_RESET;
      vbe_q <= REG_RESET;
      mode_q <= REG_RESET;
      rdata_q <= REG_RESET;
    end else begin
      index_q <= index_d;
      ovf_q <= ovf_d;
      ext_q <= ext_d;
      curh_q <= curh_d;
      curl_q <= curl_d;
      vss_q <= vss_d;
      vse_q <= vse_d;
      vde_q <= vde_d;
      pitch_q <= pitch_d;
      ul_q <= ul_d;
      vbs_q <= vbs_d;
      vbe_q <= vbe_d;
      mode_q <= mode_d;
      rdata_q <= rdata_d;
    end
  end

  // pin synchronisers
  logic hs_rise, cc_rise;

  cvt_pin_sync u_hsync_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .pin_in(hsync_pin_in),
    .level_out(),
    .rise_out(hs_rise)
  );

  cvt_pin_sync u_cclk_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .pin_in(char_clk_pin_in),
    .level_out(),
    .rise_out(cc_rise)
  );

  // timing state
  logic [LINE_W-1:0] line_q, line_d;
  logic half_q, half_d;
  logic [1:0] cdiv_q, cdiv_d;
  logic [ADDR_W-1:0] row_q, row_d, ma_q, ma_d, addr_q, addr_d;
  cvt_timing_t tim_q, tim_d;
  logic pend_q, pend_d, irq_q, irq_d;
  logic [2:0] refr_q, refr_d;
  logic ten, line_tick, ma_tick, at_vss;
  logic [LINE_W-1:0] vss10, vde10, vbs10, vbe10;
  logic [ADDR_W-1:0] step, mx;

  always_comb begin
    ten = mode_q[MC_TIMING_EN];
    vss10 = {ovf_q[OVF_VSS9], ovf_q[OVF_VSS8], vss_q};
    vde10 = {ovf_q[OVF_VDE9], ovf_q[OVF_VDE8], vde_q};
    vbs10 = {1'b0, ovf_q[OVF_VBS8], vbs_q};
    vbe10 = {2'b00, vbe_q};
    step = {7'h00, ext_q[EXT_PITCH8], pitch_q};
    if (mode_q[MC_BYTE_MODE]) begin
      step = {step[ADDR_W-2:0], 1'b0};
    end else begin
      step = {step[ADDR_W-3:0], 2'b00};
    end
    half_d = half_q;
    line_d = line_q;
    line_tick = 1'b0;
    if (!ten) begin
      half_d = 1'b0;
      line_d = '0;
    end else if (hs_rise) begin
      half_d = ~half_q;
      line_tick = ~mode_q[MC_MULT_V] | half_q;
      if (line_tick) begin
        if (line_q == vertical_total_in) begin
          line_d = '0;
        end else begin
          line_d = line_q + 10'h001;
        end
      end
    end
    at_vss = line_tick & (line_d == vss10);
    row_d = row_q;
    ma_d = ma_q;
    cdiv_d = cdiv_q;
    ma_tick = 1'b0;
    if (ten && hs_rise) begin
      if (line_tick && line_d == '0) begin
        row_d = screen_start_in;
      end else if (line_tick) begin
        row_d = row_q + step;
      end
      ma_d = row_d;
      cdiv_d = 2'b00;
    end else if (ten && cc_rise) begin
      cdiv_d = cdiv_q + 2'b01;
      if (ul_q[UL_CNT4]) begin
        ma_tick = (cdiv_q == 2'b11);
      end else if (mode_q[MC_CNT2]) begin
        ma_tick = cdiv_q[0];
      end else begin
        ma_tick = 1'b1;
      end
      if (ma_tick) begin
        ma_d = ma_q + 16'h0001;
      end
    end
    mx = ma_q;
    if (!mode_q[MC_ROWSEL0]) begin
      mx[14] = row_scan_in[0];
    end
    if (!mode_q[MC_ROWSEL1]) begin
      mx[14] = row_scan_in[1];
    end
    if (ul_q[UL_DWORD]) begin
      addr_d = {mx[15:14], mx[11:0], mx[13:12]};
    end else if (mode_q[MC_BYTE_MODE]) begin
      addr_d = mx;
    end else if (mode_q[MC_WRAP]) begin
      addr_d = {mx[14:0], mx[15]};
    end else begin
      addr_d = {mx[15:14], mx[12:0], mx[13]};
    end
    tim_d = tim_q;
    if (!ten) begin
      tim_d.vsync = 1'b0;
      tim_d.vblank = 1'b0;
      tim_d.display_active = 1'b0;
    end else if (line_tick) begin
      if (line_d == vss10) begin
        tim_d.vsync = 1'b1;
      end else if (line_d[3:0] == vse_q[3:0]) begin
        tim_d.vsync = 1'b0;
      end
      if (line_d == vbs10) begin
        tim_d.vblank = 1'b1;
      end else if (ext_q[EXT_VBE_EXT] ? line_d == vbe10
                   : line_d[7:0] == vbe_q) begin
        tim_d.vblank = 1'b0;
      end
      if (line_d == vde10) begin
        tim_d.display_active = 1'b0;
      end else if (line_d == '0) begin
        tim_d.display_active = 1'b1;
      end
    end
    tim_d.underline = ten & (row_scan_in == ul_q[4:0]);
    tim_d.cursor_hit = ten & (ma_q == {curh_q, curl_q});
    pend_d = pend_q;
    if (clr_wr) begin
      pend_d = 1'b0;
    end
    if (at_vss && !vse_d[VSE_IRQ_DIS]) begin
      pend_d = 1'b1;
    end
    irq_d = pend_d & ~vse_d[VSE_IRQ_DIS];
    refr_d = vse_q[VSE_REFRESH] ? REFRESH_HI : REFRESH_LO;
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      line_q <= '0;
      half_q <= 1'b0;
      cdiv_q <= 2'b00;
      row_q <= '0;
      ma_q <= '0;
      addr_q <= '0;
      tim_q <= '0;
      pend_q <= 1'b0;
      irq_q <= 1'b0;
      refr_q <= REFRESH_LO;
    end else begin
      line_q <= line_d;
      half_q <= half_d;
      cdiv_q <= cdiv_d;
      row_q <= row_d;
      ma_q <= ma_d;
      addr_q <= addr_d;
      tim_q <= tim_d;
      pend_q <= pend_d;
      irq_q <= irq_d;
      refr_q <= refr_d;
    end
  end

  assign io_rdata_out = rdata_q;
  assign timing_out = tim_q;
  assign mem_addr_out = addr_q;
  assign refresh_count_out = refr_q;
  assign vertical_irq_pending_out = pend_q;
  assign irq_out = irq_q;

  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  sequence s_timing_off;
    !mode_q[MC_TIMING_EN] [*2];
  endsequence

  sequence s_prot_wr;
    data_wr && index_q == IDX_OVERFLOW && vse_q[VSE_PROTECT];
  endsequence

  irq_disable_gate_a: assert property (
    vse_q[VSE_IRQ_DIS] |-> !irq_q)
    else $error("interrupt active while disabled");
  irq_clear_write_a: assert property (
    clr_wr && !at_vss |=> !pend_q && !irq_q)
    else $error("pending not cleared by clear write");
  irq_set_line_a: assert property (
    at_vss && !vse_d[VSE_IRQ_DIS] |=> pend_q && irq_q)
    else $error("pending not set at sync start");
  vsync_start_a: assert property (
    ten && line_tick && line_d == vss10 |=> tim_q.vsync)
    else $error("vsync not started at sync start line");
  vsync_end_a: assert property (
    ten && line_tick && line_d != vss10 && line_d[3:0] == vse_q[3:0]
    |=> !tim_q.vsync)
    else $error("vsync not ended on end match");
  protect_ovf_a: assert property (
    s_prot_wr |=> (ovf_q & ~OVF_WMASK_PROT)
      == $past(ovf_q & ~OVF_WMASK_PROT))
    else $error("protected overflow bits changed");
  refresh_count_a: assert property (
    $stable(vse_q) |-> refr_q == (vse_q[VSE_REFRESH] ? 3'h5 : 3'h3))
    else $error("wrong refresh cycle count");
  timing_hold_off_a: assert property (
    s_timing_off |-> line_q == '0 && !tim_q.vsync && !tim_q.vblank)
    else $error("timing ran while disabled");
  line_step_a: assert property (
    ten && line_tick && line_d != '0
    |=> row_q == $past(row_q) + $past(step))
    else $error("row start did not advance by offset");
endmodule : cvt_vertical_timing
`default_nettype wire
